// ===== rtl/blfp_pkg.sv
/*
  Constants for the boot lock flash protection block: register
  offsets, store command codes, field positions and reset values.
  Assumes a 32-bit AHB-Lite register bus, one register per word.
*/
`default_nettype none

package blfp_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_PTR_EXT = 8'h00;
  localparam logic [7:0] A_PTR_HI  = 8'h04;
  localparam logic [7:0] A_PTR_LO  = 8'h08;
  localparam logic [7:0] A_CTRL    = 8'h0c;
  localparam logic [7:0] A_DATA    = 8'h10;
  localparam logic [7:0] A_EXEC    = 8'h14;
  localparam logic [7:0] A_LOAD    = 8'h18;
  localparam logic [7:0] A_LOCK    = 8'h1c;
  localparam logic [7:0] A_STAT    = 8'h20;
  localparam logic [7:0] A_CFG     = 8'h24;
  localparam logic [7:0] A_LDATA   = 8'h28;

  // ------------------------------------------------------------
  // Store command patterns in the store control register
  // ------------------------------------------------------------
  localparam logic [4:0] CMD_FILL  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_RWWRE = 5'h11;

  // Cycles a command stays armed after the control write
  localparam logic [2:0] STORE_WIN = 3'h4;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int LK_BOOT_HI = 5;
  localparam int LK_BOOT_LO = 4;
  localparam int LK_APP_HI  = 3;
  localparam int LK_APP_LO  = 2;
  localparam logic [5:0] LOCK_ERASED = 6'h3f;
  localparam int ST_BUSY    = 0;
  localparam int ST_DENIED  = 1;
  localparam int ST_LDVALID = 2;
  localparam int ST_ARMED   = 3;
  localparam int CFG_EXEC_BOOT = 0;
  localparam int CFG_VEC_BOOT  = 1;
  localparam logic [15:0] BUF_ERASED = 16'hffff;
  localparam logic [7:0]  LEGACY_64K = 8'h00;

  typedef enum logic [1:0] {S_IDLE, S_FLASH, S_LOAD} blfp_state_type;

endpackage

`default_nettype wire

// ===== rtl/blfp_lock_check.sv
/*
  Lock decode: from the two boot lock fields, the executing section
  and the target section, says whether a store or a load may go and
  whether interrupts must be held off. Purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none

module blfp_lock_check
  import blfp_pkg::*;
(
  // Lock state
  input  wire logic [5:0] lock,
  // Access context
  input  wire logic       exec_boot,
  input  wire logic       vec_boot,
  input  wire logic       addr_boot,
  // Verdicts
  output logic            store_ok,
  output logic            load_ok,
  output logic            irq_block
);

  // ------------------------------------------------------------
  // Section verdicts; general lock bits 1..0 are never consulted
  // ------------------------------------------------------------
  // Store blocked exactly when the section's low bit is programmed
  assign store_ok = addr_boot ? lock[LK_BOOT_LO]
                              : lock[LK_APP_LO];
  // Cross-section loads blocked when the high bit is programmed
  assign load_ok = addr_boot ? (exec_boot | lock[LK_BOOT_HI])
                             : (!exec_boot | lock[LK_APP_HI]);
  // Vectors in the other section would fetch protected code
  assign irq_block = (!exec_boot && !lock[LK_APP_HI] && vec_boot)
                  || (exec_boot && !lock[LK_BOOT_HI] && !vec_boot);

endmodule

`default_nettype wire

// ===== rtl/blfp_page_buf.sv
/*
  Temporary page buffer: one word per entry, each entry writable once
  until the buffer is cleared. Unwritten entries read as erased.
  Assumes the writer and the flash array share ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module blfp_page_buf
  import blfp_pkg::*;
#(
  parameter int WORD_BITS = 7
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Fill side
  input  wire logic                 wr_en,
  input  wire logic [WORD_BITS-1:0] wr_idx,
  input  wire logic [15:0]          wr_data,
  input  wire logic                 clr,
  // Flash array side
  input  wire logic [WORD_BITS-1:0] rd_idx,
  output logic      [15:0]          rd_data
);

  localparam int DEPTH = 1 << WORD_BITS;

  logic [15:0]      mem [DEPTH];
  logic [DEPTH-1:0] valid;

  // ------------------------------------------------------------
  // Entry valid bits, cleared by reset and by clear
  // ------------------------------------------------------------
  for (genvar g = 0; g < DEPTH; g++) begin : g_valid
    always_ff @(posedge ref_clk) begin
      if (reset || clr) begin
        valid[g] <= 1'b0;
      end else if (wr_en && wr_idx == WORD_BITS'(g)) begin
        valid[g] <= 1'b1;
      end
    end
  end

  // Second write to an entry is dropped until a clear
  always_ff @(posedge ref_clk) begin
    if (wr_en && !valid[wr_idx]) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // Registered read port for the flash array
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_data <= BUF_ERASED;
    end else begin
      rd_data <= valid[rd_idx] ? mem[rd_idx] : BUF_ERASED;
    end
  end

  property p_buf_clear;
    @(posedge ref_clk) disable iff (reset)
    clr |=> valid == '0;
  endproperty
  a_buf_clear: assert property (p_buf_clear)
    else $error("page buffer not cleared");

  property p_buf_fill;
    @(posedge ref_clk) disable iff (reset)
    wr_en && !clr |=> valid[$past(wr_idx)];
  endproperty
  a_buf_fill: assert property (p_buf_fill)
    else $error("fill did not mark entry");

endmodule

`default_nettype wire

// ===== rtl/blfp_top.sv
/*
  Boot lock flash protection top: AHB-Lite register slave, pointer,
  store command window, lock bits and the flash array request port.
  Assumes a flash array on ref_clk that answers a load in the same
  cycle as the address and a request with a flash_done pulse.
*/
`timescale 1ns/1ps
`default_nettype none

module blfp_top
  import blfp_pkg::*;
#(
  parameter int          FLASH_BYTES = 65536,
  parameter int          WORD_BITS   = 7,
  parameter logic [23:0] BOOT_START  = 24'h00e000
)
(
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic      [31:0]           hrdata,
  // Programming interface and lock storage pins
  input  wire logic                  chip_erase_pin,
  input  wire logic                  prog_lock_we_pin,
  input  wire logic [5:0]            prog_lock_data_pin,
  input  wire logic [5:0]            lock_nv_in,
  output logic                       lock_nv_we,
  output logic      [5:0]            lock_nv_data,
  // Flash array
  output logic                       flash_req,
  output logic                       flash_op_write,
  output logic      [23-WORD_BITS:0] flash_page,
  input  wire logic                  flash_done,
  output logic      [23:0]           flash_rd_addr,
  input  wire logic [7:0]            flash_rd_data,
  input  wire logic [WORD_BITS-1:0]  flash_buf_idx,
  output logic      [15:0]           flash_buf_word,
  // Interrupt hold-off to the core
  output logic                       irq_block
);

  localparam bit EXT_EN = FLASH_BYTES > 65536;
  localparam int PG_LSB = WORD_BITS + 1;

  blfp_state_type state;
  logic        dp_act;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        wr;
  logic [7:0]  ptr_ext;
  logic [7:0]  ptr_hi;
  logic [7:0]  ptr_lo;
  logic [23:0] ptr;
  logic [4:0]  cmd;
  logic [2:0]  arm_cnt;
  logic [15:0] store_data;
  logic [1:0]  cfg;
  logic [5:0]  lock;
  logic        lock_loaded;
  logic        denied;
  logic        ld_valid;
  logic [7:0]  load_data;
  logic [13:0] sync1;
  logic [13:0] sync2;
  logic [1:0]  strobe_d;
  logic        erase_evt;
  logic        prog_evt;
  logic        exec_go;
  logic        load_go;
  logic        addr_boot;
  logic        st_ok;
  logic        ld_ok;
  logic        deny_now;
  logic        lockset;
  logic        buf_we;
  logic        buf_clr;
  logic [31:0] next_hrdata;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // Zero wait states; every answer is OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture; the low byte selects the register, upper address bits must be zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dp_act  <= 1'b0;
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_act  <= hsel && htrans[1] && haddr[31:8] == 24'h0;
      dp_wr   <= hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  assign wr = dp_act && dp_wr;

  // Read mux; a read right after a write sees the old value
  always_comb begin
    next_hrdata = 32'h0;
    case (haddr[7:0])
      A_PTR_EXT: next_hrdata[7:0] = ptr_ext;
      A_PTR_HI:  next_hrdata[7:0] = ptr_hi;
      A_PTR_LO:  next_hrdata[7:0] = ptr_lo;
      A_CTRL:    next_hrdata[4:0] = cmd;
      A_DATA:    next_hrdata[15:0] = store_data;
      A_LOCK:    next_hrdata[5:0] = lock;
      A_STAT: begin
        next_hrdata[ST_BUSY]    = state != S_IDLE;
        next_hrdata[ST_DENIED]  = denied;
        next_hrdata[ST_LDVALID] = ld_valid;
        next_hrdata[ST_ARMED]   = arm_cnt != 3'h0;
      end
      A_CFG:     next_hrdata[1:0] = cfg;
      A_LDATA:   next_hrdata[7:0] = load_data;
      default:   next_hrdata = 32'h0;
    endcase
    if (haddr[31:8] != 24'h0) begin
      next_hrdata = 32'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ------------------------------------------------------------
  // Pointer and data registers
  // ------------------------------------------------------------
  // Extension byte exists only on large parts
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_ext <= LEGACY_64K;
    end else if (EXT_EN && wr && dp_addr == A_PTR_EXT) begin
      ptr_ext <= hwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ptr_hi <= 8'h00;
      ptr_lo <= 8'h00;
    end else if (wr && dp_addr == A_PTR_HI) begin
      ptr_hi <= hwdata[7:0];
    end else if (wr && dp_addr == A_PTR_LO) begin
      ptr_lo <= hwdata[7:0];
    end
  end

  assign ptr = {ptr_ext, ptr_hi, ptr_lo};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      store_data <= 16'h0;
      cfg        <= 2'b00;
    end else if (wr && dp_addr == A_DATA) begin
      store_data <= hwdata[15:0];
    end else if (wr && dp_addr == A_CFG) begin
      cfg <= hwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Store command window
  // ------------------------------------------------------------
  // Command auto-clears when the window lapses or it is used
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd     <= 5'h0;
      arm_cnt <= 3'h0;
    end else if (wr && dp_addr == A_CTRL) begin
      cmd     <= hwdata[4:0];
      arm_cnt <= STORE_WIN;
    end else if (exec_go || arm_cnt == 3'h1) begin
      cmd     <= 5'h0;
      arm_cnt <= 3'h0;
    end else if (arm_cnt != 3'h0) begin
      arm_cnt <= arm_cnt - 3'h1;
    end
  end

  // Stores only act idle with locks loaded, and from boot code except CMD_RWWRE
  assign exec_go = wr && dp_addr == A_EXEC && arm_cnt != 3'h0
                && state == S_IDLE && lock_loaded;
  assign load_go = wr && dp_addr == A_LOAD && state == S_IDLE
                && lock_loaded;

  // ------------------------------------------------------------
  // Lock decode
  // ------------------------------------------------------------
  assign addr_boot = ptr >= BOOT_START;

  blfp_lock_check u_check (
    .lock      (lock),
    .exec_boot (cfg[CFG_EXEC_BOOT]),
    .vec_boot  (cfg[CFG_VEC_BOOT]),
    .addr_boot (addr_boot),
    .store_ok  (st_ok),
    .load_ok   (ld_ok),
    .irq_block (irq_block)
  );

  // Pointer ignored: lock set never looks at ptr
  assign lockset = exec_go && cmd == CMD_LOCK
                && cfg[CFG_EXEC_BOOT];

  // Erase and write need store rights on the target section
  assign deny_now = (exec_go && !cfg[CFG_EXEC_BOOT])
                 || (exec_go && !st_ok
                     && (cmd == CMD_ERASE || cmd == CMD_WRITE))
                 || (load_go && !ld_ok);

  // ------------------------------------------------------------
  // Programming pin synchronisers
  // ------------------------------------------------------------
  // No reset here: the stored locks must already stand when reset ends
  always_ff @(posedge ref_clk) begin
    sync1 <= {chip_erase_pin, prog_lock_we_pin,
              prog_lock_data_pin, lock_nv_in};
    sync2 <= sync1;
  end

  // Edge history; pins idle low, so no false edge after reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      strobe_d <= 2'b00;
    end else begin
      strobe_d <= sync2[13:12];
    end
  end

  assign erase_evt = sync2[13] && !strobe_d[1];
  assign prog_evt  = sync2[12] && !strobe_d[0];

  // ------------------------------------------------------------
  // Lock bits
  // ------------------------------------------------------------
  // Reset reloads from storage; no path here sets a bit except erase
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock        <= LOCK_ERASED;
      lock_loaded <= 1'b0;
    end else if (!lock_loaded) begin
      lock        <= sync2[5:0];
      lock_loaded <= 1'b1;
    end else if (erase_evt) begin
      lock <= LOCK_ERASED;
    end else if (prog_evt) begin
      lock <= lock & sync2[11:6];
    end else if (lockset) begin
      lock <= lock & store_data[5:0];
    end
  end

  // Write-back to storage strobes in the same cycle each erase, pin program or lock set result appears; the load from storage is not written back
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lock_nv_we <= 1'b0;
    end else begin
      lock_nv_we <= lock_loaded && (erase_evt || prog_evt || lockset);
    end
  end

  assign lock_nv_data = lock;

  // ------------------------------------------------------------
  // Page buffer
  // ------------------------------------------------------------
  assign buf_we  = exec_go && cmd == CMD_FILL && cfg[CFG_EXEC_BOOT];
  assign buf_clr = (exec_go && cmd == CMD_RWWRE)
                || (state == S_FLASH && flash_done && flash_op_write);

  blfp_page_buf #(
    .WORD_BITS (WORD_BITS)
  ) u_buf (
    .ref_clk (ref_clk),
    .reset   (reset),
    .wr_en   (buf_we),
    .wr_idx  (ptr[WORD_BITS:1]),
    .wr_data (store_data),
    .clr     (buf_clr),
    .rd_idx  (flash_buf_idx),
    .rd_data (flash_buf_word)
  );

  // ------------------------------------------------------------
  // Operation sequencer
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (exec_go && !deny_now
              && (cmd == CMD_ERASE || cmd == CMD_WRITE)) begin
            state <= S_FLASH;
          end else if (load_go && ld_ok) begin
            state <= S_LOAD;
          end
        end
        S_FLASH: begin
          if (flash_done) begin
            state <= S_IDLE;
          end
        end
        S_LOAD:  state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // Page is latched once; later pointer writes cannot move it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flash_req      <= 1'b0;
      flash_op_write <= 1'b0;
      flash_page     <= '0;
    end else if (state == S_IDLE && exec_go && !deny_now
                 && (cmd == CMD_ERASE || cmd == CMD_WRITE)) begin
      flash_req      <= 1'b1;
      flash_op_write <= cmd == CMD_WRITE;
      flash_page     <= {1'b0, ptr[23:PG_LSB]};
    end else if (state == S_FLASH && flash_done) begin
      flash_req <= 1'b0;
    end
  end

  // Byte-wide load address keeps bit zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flash_rd_addr <= 24'h0;
    end else if (load_go && ld_ok) begin
      flash_rd_addr <= ptr;
    end
  end

  // Forbidden loads return zero, never protected bytes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      load_data <= 8'h00;
      ld_valid  <= 1'b0;
    end else if (load_go) begin
      load_data <= 8'h00;
      ld_valid  <= !ld_ok;
    end else if (state == S_LOAD) begin
      load_data <= flash_rd_data;
      ld_valid  <= 1'b1;
    end
  end

  // Sticky refusal flag; write one to clear, a new refusal wins
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      denied <= 1'b0;
    end else if (deny_now) begin
      denied <= 1'b1;
    end else if (wr && dp_addr == A_STAT && hwdata[ST_DENIED]) begin
      denied <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_bad_store;
    exec_go && !st_ok && (cmd == CMD_ERASE || cmd == CMD_WRITE);
  endsequence

  property p_store_blocked;
    @(posedge ref_clk) disable iff (reset)
    state == S_IDLE ##0 s_bad_store |=> !flash_req && denied;
  endproperty
  a_store_blocked: assert property (p_store_blocked)
    else $error("forbidden store reached flash");

  property p_no_unprogram;
    @(posedge ref_clk) disable iff (reset)
    lock_loaded && $past(lock_loaded) && (lock & ~$past(lock)) != 6'h0
      |-> $past(erase_evt);
  endproperty
  a_no_unprogram: assert property (p_no_unprogram)
    else $error("lock bit unprogrammed without erase");

  property p_page_held;
    @(posedge ref_clk) disable iff (reset)
    flash_req && $past(flash_req) |-> $stable(flash_page);
  endproperty
  a_page_held: assert property (p_page_held)
    else $error("latched page moved");

  property p_load_zero;
    @(posedge ref_clk) disable iff (reset)
    load_go && !ld_ok |=> load_data == 8'h00 && denied ##1 state == S_IDLE;
  endproperty
  a_load_zero: assert property (p_load_zero)
    else $error("protected load returned data");

  property p_irq_hold;
    @(posedge ref_clk) disable iff (reset)
    irq_block |-> cfg[CFG_VEC_BOOT] != cfg[CFG_EXEC_BOOT];
  endproperty
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt hold with local vectors");

  property p_lockset;
    @(posedge ref_clk) disable iff (reset)
    lockset && !erase_evt && !prog_evt
      |=> lock == ($past(lock) & $past(store_data[5:0]));
  endproperty
  a_lockset: assert property (p_lockset)
    else $error("lock set result wrong");

  property p_window;
    @(posedge ref_clk) disable iff (reset)
    state == S_IDLE && arm_cnt == 3'h0 && !(wr && dp_addr == A_CTRL)
      ##1 !load_go |=> state == S_IDLE;
  endproperty
  a_window: assert property (p_window)
    else $error("store acted outside window");

  property p_fill_word;
    @(posedge ref_clk) disable iff (reset)
    buf_we |-> !flash_req [*1] ##1 state == S_IDLE;
  endproperty
  a_fill_word: assert property (p_fill_word)
    else $error("fill started a flash operation");

endmodule

`default_nettype wire

// ===== verif/blfp_flash_model.sv
/*
  Flash array model: answers erase and write requests with a done
  pulse after a random busy span, returns read bytes for loads.
  Assumes the block under test shares ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module blfp_flash_model (
  // Clock
  input  wire logic        ref_clk,
  // Request side
  input  wire logic        flash_req,
  input  wire logic [23:0] flash_rd_addr,
  output logic             flash_done,
  output logic      [7:0]  flash_rd_data
);
  logic [3:0] wait_cnt;
  logic       served;

  // One done pulse per request; span varies so latching is exercised
  always_ff @(posedge ref_clk) begin
    flash_done <= 1'b0;
    if (flash_req !== 1'b1) begin
      served   <= 1'b0;
      wait_cnt <= 4'h4 + 4'($urandom % 5);
    end else if (!served) begin
      wait_cnt <= wait_cnt - 4'h1;
      if (wait_cnt == 4'h0) begin
        flash_done <= 1'b1;
        served     <= 1'b1;
      end
    end
  end

  // Byte content derived from the address, so byte select shows
  assign flash_rd_data = flash_rd_addr[7:0] ^ flash_rd_addr[15:8] ^ 8'h5a;
endmodule

`default_nettype wire

// ===== verif/tb_boot_lock_flash_protection.sv
/*
  Self-checking bench for the lock block: AHB-Lite master tasks,
  expected values queued by the driver, compared by monitors.
  Assumes the flash array model beside the block.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_boot_lock_flash_protection;
  import blfp_pkg::*;
  logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, hready, chip_erase_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_val;
  logic [1:0]  htrans = 0;
  logic        hreadyout, hresp, lock_nv_we, flash_req, flash_op_write, flash_done, irq_block;
  logic [5:0]  lock_nv_data;
  logic [16:0] flash_page;
  logic [23:0] flash_rd_addr;
  logic [7:0]  flash_rd_data, hi, lo;
  logic [15:0] flash_buf_word, d;
  logic [6:0]  flash_buf_idx = 7'h00;
  logic [31:0] rq[$], iq[$], bq[$], nq[$];
  logic [17:0] pq[$];
  int          miscompares = 0, samples_checked = 0;
  event        rd_ev, irq_ev, buf_ev;

  // Clock and bus ready from the single slave
  always #2 ref_clk = ~ref_clk;
  assign hready = hreadyout;

  blfp_top blfp_top_inst (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chip_erase_pin(chip_erase_pin),
    .prog_lock_we_pin(1'b0), .prog_lock_data_pin(6'h3f), .lock_nv_in(6'h3f),
    .lock_nv_we(lock_nv_we), .lock_nv_data(lock_nv_data), .flash_req(flash_req),
    .flash_op_write(flash_op_write), .flash_page(flash_page), .flash_done(flash_done),
    .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data), .flash_buf_idx(flash_buf_idx),
    .flash_buf_word(flash_buf_word), .irq_block(irq_block));
  blfp_flash_model blfp_flash_model_inst (.ref_clk(ref_clk), .flash_req(flash_req),
    .flash_rd_addr(flash_rd_addr), .flash_done(flash_done), .flash_rd_data(flash_rd_data));

  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Single transfer; read data taken at the data phase edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    do @(posedge ref_clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd_val = hrdata;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    rq.push_back(e);
    xfer(0, a, 0);
    -> rd_ev;
  endtask

  // Command write then trigger, well inside the armed span
  task automatic st(logic [4:0] c);
    xfer(1, A_CTRL, {27'h0, c});
    xfer(1, A_EXEC, 0);
  endtask

  // Settled level notes, looked at mid-cycle
  task automatic irq_note(logic e);
    iq.push_back({31'h0, e});
    @(negedge ref_clk);
    -> irq_ev;
  endtask

  // Buffer read port answers one cycle after the fill lands
  task automatic buf_note(logic [15:0] e);
    bq.push_back({16'h0, e});
    repeat (2) @(negedge ref_clk);
    -> buf_ev;
  endtask

  task automatic wdone();
    repeat (2) @(posedge ref_clk);
    while (flash_req !== 1'b0) @(posedge ref_clk);
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Monitors: bus reads, the page held at flash completion, lock write-back, irq and buffer notes
  always @(rd_ev) cmp("hrdata", (rq.size() > 0) ? rq.pop_front() : 32'hdead, rd_val);
  always @(negedge ref_clk) begin
    if (flash_done === 1'b1 && flash_req === 1'b1) begin
      cmp("flash_op_page", (pq.size() > 0) ? {14'h0, pq.pop_front()} : 32'hdead,
          {14'h0, flash_op_write, flash_page});
    end
    if (lock_nv_we === 1'b1) begin
      cmp("lock_nv_data", (nq.size() > 0) ? nq.pop_front() : 32'hdead,
          {26'h0, lock_nv_data});
    end
  end
  always @(irq_ev) cmp("irq_block", (iq.size() > 0) ? iq.pop_front() : 32'hdead,
                       {31'h0, irq_block});
  always @(buf_ev) cmp("flash_buf_word", (bq.size() > 0) ? bq.pop_front() : 32'hdead,
                       {16'h0, flash_buf_word});

  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h09d0));
    repeat (6) @(posedge ref_clk);
    reset <= 0;
    repeat (2) @(posedge ref_clk);
    xfer(1, A_CFG, 32'h1);
    rd(A_LOCK, 32'h3f);
    rd(8'h2c, 32'h0);
    xfer(1, A_PTR_EXT, 32'hff);
    rd(A_PTR_EXT, 32'h0);
    hi = 8'($urandom % 224);
    lo = 8'($urandom);
    xfer(1, A_PTR_HI, {24'h0, hi});
    xfer(1, A_PTR_LO, {24'h0, lo});
    xfer(1, A_LOAD, 0);
    rd(A_LDATA, {24'h0, lo ^ hi ^ 8'h5a});
    xfer(1, A_DATA, 32'h30);
    nq.push_back(32'h30);
    st(CMD_LOCK);
    rd(A_LOCK, 32'h30);
    xfer(1, A_LOAD, 0);
    rd(A_LDATA, 32'h0);
    rd(A_STAT, 32'h6);
    xfer(1, A_STAT, 32'h2);
    rd(A_STAT, 32'h4);
    st(CMD_ERASE);
    rd(A_STAT, 32'h6);
    hi = 8'he0 + 8'($urandom % 32);
    xfer(1, A_PTR_HI, {24'h0, hi});
    pq.push_back({1'b0, 9'h0, hi});
    st(CMD_ERASE);
    xfer(1, A_PTR_HI, 32'h0);
    wdone();
    xfer(1, A_PTR_HI, {24'h0, hi});
    pq.push_back({1'b1, 9'h0, hi});
    st(CMD_WRITE);
    wdone();
    flash_buf_idx <= lo[7:1];
    d = 16'($urandom);
    xfer(1, A_DATA, {16'h0, d});
    st(CMD_FILL);
    buf_note(d);
    xfer(1, A_DATA, {16'h0, ~d});
    st(CMD_FILL);
    buf_note(d);
    st(CMD_RWWRE);
    buf_note(16'hffff);
    xfer(1, A_CFG, 32'h2);
    irq_note(1'b1);
    nq.push_back(32'h3f);
    chip_erase_pin <= 1;
    repeat (6) @(posedge ref_clk);
    chip_erase_pin <= 0;
    repeat (6) @(posedge ref_clk);
    rd(A_LOCK, 32'h3f);
    irq_note(1'b0);
    tally_and_finish();
  end
endmodule

`default_nettype wire
